// [rtl/plc_supervisor_defs.vh]
// Constants for the programmable-controller mode and fault supervisor.
// Assumes a 100 MHz aclk and AXI4-Lite register access with 32-bit data.
`ifndef PLC_SUPERVISOR_DEFS_VH
`define PLC_SUPERVISOR_DEFS_VH
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_WDT_LIMIT 8'h08
`define REG_EDGE_CFG 8'h0c
`define REG_INT_PEND 8'h10
`define REG_FORCE_IN_EN 8'h14
`define REG_FORCE_IN_DATA 8'h18
`define REG_FORCE_OUT_EN 8'h1c
`define REG_FORCE_OUT_DATA 8'h20
`define REG_OUT_IMAGE 8'h24
`define REG_IN_IMAGE 8'h28
`define REG_ERR_CLEAR 8'h2c
`define REG_PERIOD_BASE 8'h40
`define CTRL_HOST_CMD_LSB 0
`define CTRL_ALL_OFF 2
`define CTRL_WDT_KICK 3
`define CTRL_STOP_INSTR 4
`define CTRL_END_SCAN 5
`define CTRL_NUM_ERR 6
`define CTRL_INT_DONE 7
`define CTRL_PROG_VALID 8
`define HOST_RUN 2'h1
`define HOST_STOP 2'h0
`define HOST_PAUSE 2'h2
`define KEY_STOP 2'h0
`define KEY_RUN 2'h1
`define KEY_REMOTE 2'h2
`define WDT_LIMIT_RESET 32'h000f4240
`define FLASH_HALF_NS 100000000
`define CLK_PERIOD_NS 10
`define FLASH_HALF_CYCLES (`FLASH_HALF_NS / `CLK_PERIOD_NS)
`endif

// [rtl/plc_mode_fault_supervisor.v]
// Mode, fault, watchdog, interrupt and forced I/O supervisor for a controller card.
// Assumes an AXI4-Lite master with one transaction of each kind under way at a time.
`timescale 1ns/10ps
`include "plc_supervisor_defs.vh"
module plc_mode_fault_supervisor #(
  parameter n_in = 16,
  parameter n_out = 16,
  parameter flash_half = `FLASH_HALF_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] mode_key,
  input wire [n_in-1:0] field_in,
  input wire config_mismatch,
  input wire io_module_fault,
  input wire self_diag_fault,
  input wire ordinary_fault,
  output reg [n_out-1:0] field_out,
  output reg run_mode,
  output reg stop_mode,
  output reg pause_mode,
  output reg run_led,
  output reg err_led,
  output reg warn_led,
  output reg system_error_flag,
  output reg program_enable,
  output reg data_init,
  output reg int_active,
  output reg [7:0] periodic_interrupt_entry,
  output reg [5:0] input_edge_interrupt
);
  localparam st_stop = 3'b001;
  localparam st_run = 3'b010;
  localparam st_pause = 3'b100;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] key_s1, key_s2;
  reg [n_in-1:0] in_s1, in_s2;
  reg [3:0] flt_s1, flt_s2;
  reg [5:0] edge_prev;
  reg [1:0] host_cmd;
  reg all_off;
  reg [15:0] edge_cfg;
  reg [n_in-1:0] force_in_en, force_in_data, in_image;
  reg [n_out-1:0] force_out_en, force_out_data, out_image;
  reg [31:0] wdt_limit, wdt_cnt;
  reg wdt_expired;
  reg fatal, num_err;
  reg prog_valid;
  reg [31:0] period [0:7];
  reg [31:0] period_cnt [0:7];
  reg [7:0] per_hit;
  reg [5:0] edge_hit;
  reg [31:0] flash_cnt;
  reg flash;
  reg aw_got, w_got;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire [31:0] wr_val;
  wire do_write;
  wire ctrl_wr;
  wire any_fatal;
  wire [n_out-1:0] pin_value;
  integer k;
  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign wr_val = w_data;
  assign ctrl_wr = do_write && (aw_addr == `REG_CTRL);
  // Fatal causes all land in stop; ordinary ones warn and set the system error flag.
  assign any_fatal = flt_s2[0] | flt_s2[1] | flt_s2[2] | wdt_expired;
  // Forced outputs alter only the pins, and all-off beats them.
  assign pin_value = (out_image & ~force_out_en) | (force_out_data & force_out_en);

  // Two-stage synchronisers for key, field inputs and fault pins.
  always @(posedge aclk) begin
    if (!aresetn) begin
      key_s1 <= 2'h0;
      key_s2 <= 2'h0;
      in_s1 <= {n_in{1'b0}};
      in_s2 <= {n_in{1'b0}};
      flt_s1 <= 4'h0;
      flt_s2 <= 4'h0;
    end else begin
      key_s1 <= mode_key;
      key_s2 <= key_s1;
      in_s1 <= field_in;
      in_s2 <= in_s1;
      flt_s1 <= {ordinary_fault, self_diag_fault, io_module_fault, config_mismatch};
      flt_s2 <= flt_s1;
    end
  end

  // Mode selection: faults first, then key, then host, then program stop.
  always @* begin
    next_state = state;
    if (fatal || any_fatal) begin
      next_state = st_stop;
    end else if (key_s2 == `KEY_RUN) begin
      next_state = st_run;
    end else if (key_s2 == `KEY_STOP) begin
      next_state = st_stop;
    end else if (key_s2 == `KEY_REMOTE) begin
      case (host_cmd)
        `HOST_RUN: next_state = st_run;
        `HOST_PAUSE: next_state = (state == st_stop) ? st_stop : st_pause;
        default: next_state = st_stop;
      endcase
    end
    if (ctrl_wr && wr_val[`CTRL_STOP_INSTR] && state == st_run) begin
      next_state = st_stop;
    end
    case (next_state)
      st_stop, st_run, st_pause: next_state = next_state;
      default: next_state = st_stop;
    endcase
  end

  // Mode register and mode-entry actions.
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_stop;
      host_cmd <= `HOST_STOP;
      data_init <= 1'b0;
      out_image <= {n_out{1'b0}};
      in_image <= {n_in{1'b0}};
    end else begin
      state <= next_state;
      data_init <= (next_state == st_run) && (state == st_stop);
      if (next_state == st_stop && state != st_stop) begin
        out_image <= {n_out{1'b0}};
      end else if (do_write && aw_addr == `REG_OUT_IMAGE && state == st_run) begin
        out_image <= wr_val[n_out-1:0];
      end
      if (state != st_pause) begin
        in_image <= (in_s2 & ~force_in_en) | (force_in_data & force_in_en);
      end
      if (key_s2 == `KEY_RUN) begin
        host_cmd <= `HOST_RUN;
      end else if (key_s2 == `KEY_STOP) begin
        host_cmd <= `HOST_STOP;
      end else if (ctrl_wr && wr_val[`CTRL_STOP_INSTR] && state == st_run) begin
        host_cmd <= `HOST_STOP;
      end else if (ctrl_wr && w_strb[0]) begin
        host_cmd <= wr_val[`CTRL_HOST_CMD_LSB+1:`CTRL_HOST_CMD_LSB];
      end
    end
  end

  // Watchdog restarted at end of scan or by the kick instruction.
  always @(posedge aclk) begin
    if (!aresetn) begin
      wdt_cnt <= 32'h0;
      wdt_expired <= 1'b0;
    end else if (state != st_run) begin
      wdt_cnt <= 32'h0;
      wdt_expired <= wdt_expired && !(do_write && aw_addr == `REG_ERR_CLEAR);
    end else if (ctrl_wr && (wr_val[`CTRL_END_SCAN] || wr_val[`CTRL_WDT_KICK])) begin
      wdt_cnt <= 32'h0;
    end else if (wdt_cnt >= wdt_limit) begin
      wdt_expired <= 1'b1;
    end else begin
      wdt_cnt <= wdt_cnt + 32'h1;
    end
  end

  // Sticky errors; setting wins over software clear.
  always @(posedge aclk) begin
    if (!aresetn) begin
      fatal <= 1'b0;
      num_err <= 1'b0;
      system_error_flag <= 1'b0;
      prog_valid <= 1'b0;
    end else begin
      fatal <= any_fatal | (fatal & ~(do_write && aw_addr == `REG_ERR_CLEAR));
      num_err <= (ctrl_wr & wr_val[`CTRL_NUM_ERR]) |
        (num_err & ~(do_write && aw_addr == `REG_ERR_CLEAR));
      system_error_flag <= any_fatal | flt_s2[3] | (ctrl_wr & wr_val[`CTRL_NUM_ERR]) |
        (system_error_flag & ~(do_write && aw_addr == `REG_ERR_CLEAR));
      if (ctrl_wr) begin
        prog_valid <= wr_val[`CTRL_PROG_VALID];
      end
    end
  end

  // Periodic interrupt timers, one per source.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : per_gen
      always @(posedge aclk) begin
        if (!aresetn) begin
          period_cnt[g] <= 32'h0;
          per_hit[g] <= 1'b0;
        end else if (state != st_run || period[g] == 32'h0) begin
          period_cnt[g] <= 32'h0;
          per_hit[g] <= 1'b0;
        end else if (period_cnt[g] + 32'h1 >= period[g]) begin
          period_cnt[g] <= 32'h0;
          per_hit[g] <= 1'b1;
        end else begin
          period_cnt[g] <= period_cnt[g] + 32'h1;
          per_hit[g] <= 1'b0;
        end
      end
    end
    for (g = 0; g < 6; g = g + 1) begin : edge_gen
      always @(posedge aclk) begin
        if (!aresetn) begin
          edge_prev[g] <= 1'b0;
          edge_hit[g] <= 1'b0;
        end else begin
          edge_prev[g] <= in_image[g];
          edge_hit[g] <= (state == st_run) &&
            ((edge_cfg[2*g] && in_image[g] && !edge_prev[g]) ||
             (edge_cfg[2*g+1] && !in_image[g] && edge_prev[g]));
        end
      end
    end
  endgenerate

  // Pending interrupts; routine completion resumes the scan.
  always @(posedge aclk) begin
    if (!aresetn) begin
      periodic_interrupt_entry <= 8'h0;
      input_edge_interrupt <= 6'h0;
      int_active <= 1'b0;
    end else begin
      if (ctrl_wr && wr_val[`CTRL_INT_DONE]) begin
        periodic_interrupt_entry <= per_hit;
        input_edge_interrupt <= edge_hit;
      end else begin
        periodic_interrupt_entry <= periodic_interrupt_entry | per_hit;
        input_edge_interrupt <= input_edge_interrupt | edge_hit;
      end
      int_active <= (state == st_run) && ((|periodic_interrupt_entry) ||
        (|input_edge_interrupt));
    end
  end

  // Outputs, indicators and error flashing.
  always @(posedge aclk) begin
    if (!aresetn) begin
      field_out <= {n_out{1'b0}};
      run_mode <= 1'b0;
      stop_mode <= 1'b1;
      pause_mode <= 1'b0;
      run_led <= 1'b0;
      err_led <= 1'b0;
      warn_led <= 1'b0;
      program_enable <= 1'b0;
      flash_cnt <= 32'h0;
      flash <= 1'b0;
    end else begin
      if (flash_cnt + 32'h1 >= flash_half) begin
        flash_cnt <= 32'h0;
        flash <= ~flash;
      end else begin
        flash_cnt <= flash_cnt + 32'h1;
      end
      if (wdt_expired || all_off) begin
        field_out <= {n_out{1'b0}};
      end else if (state == st_stop) begin
        field_out <= (force_out_data & force_out_en);
      end else begin
        field_out <= pin_value;
      end
      run_mode <= state == st_run;
      stop_mode <= state == st_stop;
      pause_mode <= state == st_pause;
      run_led <= state == st_run && !wdt_expired;
      err_led <= wdt_expired ? flash : fatal;
      warn_led <= num_err | flt_s2[3];
      program_enable <= state == st_run && prog_valid && !int_active;
    end
  end

  // AXI4-Lite write channel: address and data taken in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      all_off <= 1'b0;
      wdt_limit <= `WDT_LIMIT_RESET;
      edge_cfg <= 16'h0;
      force_in_en <= {n_in{1'b0}};
      force_in_data <= {n_in{1'b0}};
      force_out_en <= {n_out{1'b0}};
      force_out_data <= {n_out{1'b0}};
      for (k = 0; k < 8; k = k + 1) begin
        period[k] <= 32'h0;
      end
    end else begin
      s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_addr)
          `REG_CTRL: all_off <= wr_val[`CTRL_ALL_OFF];
          `REG_WDT_LIMIT: wdt_limit <= wr_val;
          `REG_EDGE_CFG: edge_cfg <= wr_val[15:0];
          `REG_FORCE_IN_EN: force_in_en <= wr_val[n_in-1:0];
          `REG_FORCE_IN_DATA: force_in_data <= wr_val[n_in-1:0];
          `REG_FORCE_OUT_EN: force_out_en <= wr_val[n_out-1:0];
          `REG_FORCE_OUT_DATA: force_out_data <= wr_val[n_out-1:0];
          `REG_OUT_IMAGE, `REG_ERR_CLEAR: s_axi_bresp <= 2'h0;
          default: begin
            if (aw_addr[7:5] == 3'h2 && aw_addr[1:0] == 2'h0) begin
              period[aw_addr[4:2]] <= wr_val;
            end else begin
              s_axi_bresp <= 2'h2;
            end
          end
        endcase
      end
    end
  end

  // AXI4-Lite read channel.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `REG_CTRL: s_axi_rdata <= {23'h0, prog_valid, 3'h0, all_off, 2'h0, host_cmd};
          `REG_STATUS: s_axi_rdata <= {20'h0, flt_s2, wdt_expired, num_err, fatal,
            system_error_flag, 1'b0, state};
          `REG_WDT_LIMIT: s_axi_rdata <= wdt_limit;
          `REG_EDGE_CFG: s_axi_rdata <= {16'h0, edge_cfg};
          `REG_INT_PEND: s_axi_rdata <= {18'h0, input_edge_interrupt, periodic_interrupt_entry};
          `REG_FORCE_IN_EN: s_axi_rdata <= {{(32-n_in){1'b0}}, force_in_en};
          `REG_FORCE_IN_DATA: s_axi_rdata <= {{(32-n_in){1'b0}}, force_in_data};
          `REG_FORCE_OUT_EN: s_axi_rdata <= {{(32-n_out){1'b0}}, force_out_en};
          `REG_FORCE_OUT_DATA: s_axi_rdata <= {{(32-n_out){1'b0}}, force_out_data};
          `REG_OUT_IMAGE: s_axi_rdata <= {{(32-n_out){1'b0}}, out_image};
          `REG_IN_IMAGE: s_axi_rdata <= {{(32-n_in){1'b0}}, in_image};
          default: begin
            if (s_axi_araddr[7:5] == 3'h2 && s_axi_araddr[1:0] == 2'h0) begin
              s_axi_rdata <= period[s_axi_araddr[4:2]];
            end else begin
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= 2'h2;
            end
          end
        endcase
      end
    end
  end
endmodule // plc_mode_fault_supervisor

// [tb/sup_asserts.sv]
// Concurrent checks on the supervisor's mode, fault and indicator ports.
// Assumes it is bound to the supervisor top and shares its single clock.
`timescale 1ns/10ps
module sup_asserts (
  input wire aclk,
  input wire aresetn,
  input wire run_mode,
  input wire stop_mode,
  input wire pause_mode,
  input wire program_enable,
  input wire data_init,
  input wire int_active,
  input wire run_led,
  input wire warn_led,
  input wire system_error_flag,
  input wire config_mismatch,
  input wire io_module_fault,
  input wire self_diag_fault,
  input wire ordinary_fault
);
  // Every check runs on aclk and is quiet while reset is held.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_one_mode; $onehot({run_mode, stop_mode, pause_mode}); endproperty
  a_one_mode: assert property (p_one_mode) else $error("mode flags not one-hot");
  property p_cfg_stop; config_mismatch [*3] |-> ##[0:6] stop_mode; endproperty
  a_cfg_stop: assert property (p_cfg_stop) else $error("no stop on config fault");
  property p_io_stop; io_module_fault [*3] |-> ##[0:6] stop_mode; endproperty
  a_io_stop: assert property (p_io_stop) else $error("no stop on module fault");
  property p_diag_stop; self_diag_fault [*3] |-> ##[0:6] stop_mode; endproperty
  a_diag_stop: assert property (p_diag_stop) else $error("no stop on diag fault");
  property p_err_flag; (config_mismatch || io_module_fault || self_diag_fault ||
    ordinary_fault) [*3] |-> ##[0:6] system_error_flag; endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag not set");
  property p_warn; ordinary_fault [*3] |-> ##[0:6] warn_led; endproperty
  a_warn: assert property (p_warn) else $error("warning not raised");
  property p_stop_idle; stop_mode && $past(stop_mode) |-> !program_enable; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("program runs in stop");
  property p_pause_idle; pause_mode && $past(pause_mode) |-> !program_enable; endproperty
  a_pause_idle: assert property (p_pause_idle) else $error("program runs in pause");
  property p_init; data_init |=> !data_init && run_mode; endproperty
  a_init: assert property (p_init) else $error("bad data init pulse");
  property p_int_hold; int_active && $past(int_active) |-> !program_enable; endproperty
  a_int_hold: assert property (p_int_hold) else $error("scan not suspended");
  property p_led; !run_mode && !$past(run_mode) |-> !run_led; endproperty
  a_led: assert property (p_led) else $error("run indicator lit");
endmodule // sup_asserts

// [tb/field_side_model.sv]
// Field side of the card: input points, front mode key and fault lines.
// Assumes one bench process calls its tasks; all levels change after a rising edge.
`timescale 1ns/10ps
module field_side_model (
  input wire aclk,
  output reg [15:0] field_in,
  output reg [1:0] mode_key,
  output reg config_mismatch,
  output reg io_module_fault,
  output reg self_diag_fault,
  output reg ordinary_fault
);
  // Input points 4 to 7 high, key in the remote position and no faults at time zero.
  initial begin
    field_in = 16'h00f0;
    mode_key = 2'h2;
    {config_mismatch, io_module_fault, self_diag_fault, ordinary_fault} = 4'h0;
  end
  // Sets the levels of all input points.
  task set_in(input [15:0] v);
    @(posedge aclk);
    field_in <= v;
  endtask
  // Turns the key to local run, local stop or the remote position.
  task set_key(input [1:0] k);
    @(posedge aclk);
    mode_key <= k;
  endtask
  // Raises or drops the three fatal lines and the ordinary one.
  task set_fault(input [3:0] f);
    @(posedge aclk);
    {config_mismatch, io_module_fault, self_diag_fault, ordinary_fault} <= f;
  endtask
endmodule // field_side_model

// [tb/tb.sv]
// Self-checking bench for the mode and fault supervisor.
// Assumes the defs header is on the include path and the field model beside it.
`timescale 1ns/10ps
`include "plc_supervisor_defs.vh"
`define CHK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin \
  errors = errors + 1; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITC(c, m) begin n = 0; while (!(c) && n < m) begin @(posedge aclk); \
  n = n + 1; end `CHK(c, 1'b1) end
module tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, mode_key;
  wire [31:0] s_axi_rdata;
  wire [15:0] field_in, field_out;
  wire config_mismatch, io_module_fault, self_diag_fault, ordinary_fault, int_active;
  wire run_mode, stop_mode, pause_mode, run_led, err_led, warn_led, system_error_flag;
  wire program_enable, data_init;
  wire [7:0] periodic_interrupt_entry;
  wire [5:0] input_edge_interrupt;
  reg [31:0] rd_data;
  reg [1:0] rsp;
  reg v;
  integer errors = 0, tests_run = 0, n, i, inits = 0;
  // The clock toggles every half period of 5 ns.
  always #5 aclk = ~aclk;
  // Counts the data initialisation pulses seen at run entry.
  always @(posedge aclk) if (data_init === 1'b1) inits <= inits + 1;
  plc_mode_fault_supervisor #(.flash_half(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_key, .field_in,
    .config_mismatch, .io_module_fault, .self_diag_fault, .ordinary_fault, .field_out,
    .run_mode, .stop_mode, .pause_mode, .run_led, .err_led, .warn_led, .system_error_flag,
    .program_enable, .data_init, .int_active, .periodic_interrupt_entry, .input_edge_interrupt);
  field_side_model fld_u (.aclk, .field_in, .mode_key, .config_mismatch, .io_module_fault,
    .self_diag_fault, .ordinary_fault);
  // One write: address and data offered together, each released when taken.
  task wr(input [7:0] a, input [31:0] d);
    reg done;
    done = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    // Waits for the response however long it takes; the watchdog ends a hang.
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        done = 1'b1;
      end
    end
    s_axi_bready <= 1'b0;
    `CHK({s_axi_awvalid, s_axi_wvalid}, 2'b00)
  endtask
  // One read: the address is released when taken, data kept at rvalid.
  task rd(input [7:0] a);
    reg done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        {rsp, rd_data} = {s_axi_rresp, s_axi_rdata};
        done = 1'b1;
      end
    end
    s_axi_rready <= 1'b0;
    `CHK(s_axi_arvalid, 1'b0)
  endtask
  // Reset state, reset values and refused accesses.
  task t_reset;
    `CHK({run_mode, stop_mode, pause_mode, field_out}, {3'b010, 16'h0})
    rd(`REG_STATUS);
    `CHK(rd_data, 32'h1)
    rd(`REG_WDT_LIMIT);
    `CHK(rd_data, `WDT_LIMIT_RESET)
    rd(8'h30);
    `CHK({rsp, rd_data}, {2'h2, 32'h0})
    wr(8'h34, 32'h1);
    `CHK(rsp, 2'h2)
  endtask
  // Forced values in stop: enable gating, all-off priority, input image.
  task t_force;
    wr(`REG_FORCE_OUT_DATA, 32'h0a);
    repeat (4) @(posedge aclk);
    `CHK(field_out, 16'h0)
    wr(`REG_FORCE_OUT_EN, 32'h0f);
    `WAITC(field_out === 16'h000a, 8)
    wr(`REG_CTRL, 32'h4);
    `WAITC(field_out === 16'h0, 8)
    wr(`REG_CTRL, 32'h0);
    wr(`REG_FORCE_IN_EN, 32'h0f);
    wr(`REG_FORCE_IN_DATA, 32'h05);
    repeat (6) @(posedge aclk);
    rd(`REG_IN_IMAGE);
    `CHK(rd_data, 32'hf5)
  endtask
  // Program enable in run needs a valid program; pins merge image and forced bits.
  task t_run;
    wr(`REG_CTRL, 32'h1);
    repeat (4) @(posedge aclk);
    `CHK(program_enable, 1'b0)
    wr(`REG_CTRL, 32'h101);
    `WAITC(run_mode && program_enable, 10)
    `CHK(inits > 0, 1'b1)
    wr(`REG_OUT_IMAGE, 32'ha5);
    `WAITC(field_out === 16'h00aa, 8)
    rd(`REG_OUT_IMAGE);
    `CHK(rd_data, 32'ha5)
  endtask
  // Pause holds outputs; the return to run does not initialise again.
  task t_pause;
    wr(`REG_CTRL, 32'h102);
    `WAITC(pause_mode, 10)
    `CHK({program_enable, field_out}, {1'b0, 16'h00aa})
    i = inits;
    wr(`REG_CTRL, 32'h101);
    `WAITC(run_mode, 10)
    rd(`REG_OUT_IMAGE);
    `CHK({inits, rd_data}, {i, 32'ha5})
  endtask
  // Remote run to local run is seamless; local stop clears the image.
  task t_key;
    fld_u.set_key(`KEY_RUN);
    v = 1'b0;
    repeat (8) @(posedge aclk) v = v | stop_mode;
    `CHK({v, run_mode}, 2'b01)
    fld_u.set_key(`KEY_STOP);
    `WAITC(stop_mode, 10)
    rd(`REG_OUT_IMAGE);
    `CHK({rd_data, field_out}, {32'h0, 16'h000a})
    fld_u.set_key(`KEY_REMOTE);
    repeat (6) @(posedge aclk);
    `CHK(stop_mode, 1'b1)
    // A run command without the low byte strobe must leave the mode alone.
    s_axi_wstrb <= 4'he;
    wr(`REG_CTRL, 32'h101);
    s_axi_wstrb <= 4'hf;
    repeat (6) @(posedge aclk);
    `CHK(stop_mode, 1'b1)
    wr(`REG_CTRL, 32'h101);
    `WAITC(run_mode, 10)
    wr(`REG_CTRL, 32'h111);
    `WAITC(stop_mode, 10)
    repeat (4) @(posedge aclk);
    `CHK(stop_mode, 1'b1)
  endtask
  // Ordinary and numeric errors leave the card running.
  task t_ord;
    wr(`REG_CTRL, 32'h101);
    fld_u.set_fault(4'h1);
    `WAITC(warn_led && run_mode, 12)
    wr(`REG_CTRL, 32'h141);
    rd(`REG_STATUS);
    `CHK({rd_data[6], run_mode, system_error_flag}, 3'b111)
    fld_u.set_fault(4'h0);
  endtask
  // Periodic sources repeat; edge points fire only on their chosen edge.
  task t_ints;
    wr(`REG_FORCE_IN_EN, 32'h0);
    wr(`REG_PERIOD_BASE, 32'd10);
    wr(`REG_PERIOD_BASE + 8'h1c, 32'd15);
    `WAITC(periodic_interrupt_entry[0] && periodic_interrupt_entry[7], 40)
    `CHK(program_enable, 1'b0)
    wr(`REG_CTRL, 32'h181);
    `WAITC(!periodic_interrupt_entry[0], 10)
    `WAITC(periodic_interrupt_entry[0], 40)
    wr(`REG_PERIOD_BASE, 32'h0);
    wr(`REG_PERIOD_BASE + 8'h1c, 32'h0);
    wr(`REG_EDGE_CFG, 32'h9);
    fld_u.set_in(16'h00f1);
    `WAITC(input_edge_interrupt[0], 10)
    fld_u.set_in(16'h00f3);
    repeat (6) @(posedge aclk);
    `CHK(input_edge_interrupt[1], 1'b0)
    fld_u.set_in(16'h00f1);
    `WAITC(input_edge_interrupt[1], 10)
    wr(`REG_CTRL, 32'h181);
  endtask
  // Each fatal line forces stop and sets the sticky system error flag.
  task t_fatal;
    for (i = 0; i < 3; i = i + 1) begin
      wr(`REG_CTRL, 32'h101);
      `WAITC(run_mode, 10)
      fld_u.set_fault(4'h8 >> i);
      `WAITC(stop_mode && system_error_flag, 10)
      fld_u.set_fault(4'h0);
      wr(`REG_CTRL, 32'h100);
      wr(`REG_ERR_CLEAR, 32'h0);
      repeat (4) @(posedge aclk);
      `CHK(system_error_flag, 1'b0)
    end
  endtask
  // Kicks keep the scan alive; a missed end of scan trips the watchdog.
  task t_wdt;
    wr(`REG_FORCE_OUT_EN, 32'h0);
    wr(`REG_CTRL, 32'h121);
    wr(`REG_WDT_LIMIT, 32'd40);
    // End-of-scan and kick writes alternate, each restarting the count.
    repeat (4) begin
      wr(`REG_CTRL, 32'h121);
      wr(`REG_CTRL, 32'h109);
    end
    `CHK(run_mode, 1'b1)
    `WAITC(stop_mode, 100)
    `CHK({run_led, field_out}, 17'h0)
    v = err_led;
    `WAITC(err_led !== v, 12)
    rd(`REG_STATUS);
    `CHK(rd_data[7], 1'b1)
  endtask
  // Prints the verdict and ends the run.
  task end_sim;
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reset for three cycles, then the scenarios in order.
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_force;
    t_run;
    t_pause;
    t_key;
    t_ord;
    t_ints;
    t_fatal;
    t_wdt;
    end_sim;
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #200000;
    errors = errors + 1;
    end_sim;
  end
endmodule // tb
bind plc_mode_fault_supervisor sup_asserts chk_u (.aclk(aclk), .aresetn(aresetn),
  .run_mode(run_mode), .stop_mode(stop_mode), .pause_mode(pause_mode),
  .program_enable(program_enable), .data_init(data_init), .int_active(int_active),
  .run_led(run_led), .warn_led(warn_led), .system_error_flag(system_error_flag),
  .config_mismatch(config_mismatch), .io_module_fault(io_module_fault),
  .self_diag_fault(self_diag_fault), .ordinary_fault(ordinary_fault));
